// *** core/setc_down_timer.sv ***
// One decrementing timer with reload and completion flag.
// Assumes tick is a one-cycle timebase pulse and run a scan level.
`timescale 1ns/1ps
`default_nettype none
module setc_down_timer #(
  parameter int W = setc_pkg::TW
) (
  input  wire logic         mclk,    // Block clock
  input  wire logic         reset,   // Synchronous, active high
  input  wire logic         tick,    // Timebase step
  input  wire logic         run,     // Execution condition
  input  wire logic [W-1:0] preset,  // Start value in steps
  output logic      [W-1:0] present, // Present value
  output logic              done     // Completion flag
);
  if (W < 2) begin : g_chk
    $error("setc_down_timer: W too small");
  end

  // --------------------------------------------------------------
  // Count down
  // --------------------------------------------------------------
  // Preset is re-taken while idle so a new preset is seen at start
  always_ff @(posedge mclk) begin
    if (reset) begin
      present <= '0;
    end else if (!run) begin
      present <= preset;
    end else if (tick && present != '0) begin
      present <= present - W'(1);
    end
  end

  // Flag follows zero only while running
  always_ff @(posedge mclk) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= run && present == '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_timer_reload: assert property (
    !run |=> present == $past(preset) && !done)
    else $error("timer did not reload when idle");
  a_timer_step: assert property (
    run && tick && present != '0 && $past(run)
      |=> present == $past(present) - W'(1))
    else $error("timer missed a step");
  a_timer_done: assert property (
    run && present == '0 |=> done || !run)
    else $error("timer done flag missing");
  c_timer_out: cover property (run && present == '0 ##1 done);
endmodule
`default_nettype wire

// *** core/setc_pkg.sv ***
// Constants, register map and carriers of the scan timer/counter block.
// Assumes a 250 MHz mclk and one scan strobe per program scan.
package setc_pkg;
  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_PS         = 1000000000;
  localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam int TW = 14;
  localparam logic [13:0] FAST_ZERO_PRESET = 14'h2710;
  localparam logic [7:0]  KNOB_MIN = 8'h01;
  localparam logic [7:0]  KNOB_MAX = 8'hFA;
  localparam logic [1:0]  RANGE_1S   = 2'h0;
  localparam logic [1:0]  RANGE_100M = 2'h1;
  localparam logic [1:0]  RANGE_10M  = 2'h2;
  localparam int TB_1MS = 0;
  localparam int TB_10M = 1;
  localparam int TB_100M = 2;
  localparam int TB_1S = 3;
  localparam int NTIM = 5;
  localparam int T_10MS = 0;
  localparam int T_MS = 1;
  localparam int T_KNOB = 2;
  localparam int T_KNOB1 = 3;
  localparam int T_KNOB2 = 4;
  localparam int NRANGE = 8;
  // --------------------------------------------------------------
  // Register map (byte addresses) and fields
  // --------------------------------------------------------------
  localparam logic [7:0] R_TMR10_PRESET = 8'h00;
  localparam logic [7:0] R_TMRMS_PRESET = 8'h04;
  localparam logic [7:0] R_KNOB_RANGE   = 8'h08;
  localparam logic [7:0] R_FAST_PRESET  = 8'h0C;
  localparam logic [7:0] R_FAST_COUNT   = 8'h10;
  localparam logic [7:0] R_COPY         = 8'h14;
  localparam logic [7:0] R_DRUM_BASE    = 8'h18;
  localparam logic [7:0] R_DRUM_COUNT   = 8'h1C;
  localparam logic [7:0] R_DRUM_RESULT  = 8'h20;
  localparam logic [7:0] R_STATUS       = 8'h24;
  localparam logic [7:0] R_MASK         = 8'h28;
  localparam logic [7:0] R_UNIT_STATE   = 8'h2C;
  localparam logic [7:0] R_TABLE        = 8'h40;
  localparam int COPY_SEL_BIT = 16;
  localparam int ST_FAST = 0;
  localparam int ST_TMR = 1;
  localparam int ST_ZERO = 6;
  localparam int STW = 7;
  // --------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic rise_in, fall_in, latch_set, latch_reset;
    logic [NTIM-1:0] timer_run;
    logic drum_up, drum_down, drum_clear;
  } setc_cond_t;
  typedef struct packed {
    logic count_pulse, gate, clear;
  } setc_field_t;
  typedef struct packed {
    logic rise_out, fall_out, latch_q;
    logic [NTIM-1:0] timer_done;
    logic fast_count_done_flag;
    logic [NRANGE-1:0] drum_result;
  } setc_out_t;
endpackage

// *** core/setc_unit.sv ***
// Scan-driven one-shots, latch, timers, drum and fast counter, copy.
// Assumes scan_tick pulses once per scan; field inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
module setc_unit #(
  parameter int MS_CYCLES = setc_pkg::MS_CYCLES
) (
  input  wire logic                 mclk,      // 250 MHz clock
  input  wire logic                 reset,     // Sync, active high
  input  wire logic                 scan_tick, // End of program scan
  input  wire setc_pkg::setc_cond_t cond,      // Scan conditions
  input  wire setc_pkg::setc_field_t field,    // Field inputs
  input  wire logic [7:0]           knob_set,  // Front knob, tenths
  input  wire logic [7:0]           knob_one,  // Knob one setting
  input  wire logic [7:0]           knob_two,  // Knob two setting
  input  wire logic [7:0]           wb_adr_i,  // Byte address
  input  wire logic [31:0]          wb_dat_i,  // Write data
  input  wire logic [3:0]           wb_sel_i,  // Byte lanes
  input  wire logic                 wb_we_i,   // Write enable
  input  wire logic                 wb_cyc_i,  // Cycle
  input  wire logic                 wb_stb_i,  // Strobe
  output logic [31:0]               wb_dat_o,  // Read data
  output logic                      wb_ack_o,  // Acknowledge
  output setc_pkg::setc_out_t       unit_out,  // Unit results
  output logic                      irq        // Level interrupt
);
  if (MS_CYCLES < 2) begin : g_chk
    $error("setc_unit: MS_CYCLES too small");
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = dat[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [13:0] knob_val(input logic [7:0] k);
    logic [7:0] v;
    v = (k < setc_pkg::KNOB_MIN) ? setc_pkg::KNOB_MIN :
        (k > setc_pkg::KNOB_MAX) ? setc_pkg::KNOB_MAX : k;
    return {6'h00, v};
  endfunction

  function automatic logic range_tick(input logic [1:0] rg,
      input logic [3:0] tb);
    case (rg)
      setc_pkg::RANGE_100M: return tb[setc_pkg::TB_100M];
      setc_pkg::RANGE_10M:  return tb[setc_pkg::TB_10M];
      default:              return tb[setc_pkg::TB_1S];
    endcase
  endfunction

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [13:0] tmr10_preset;
  logic [13:0] tmrms_preset;
  logic [3:0]  knob_range;
  logic [13:0] fast_preset;
  logic [13:0] fast_count;
  logic [15:0] copy_dest;
  logic        copy_zero;
  logic [3:0]  drum_base;
  logic [15:0] drum_count;
  logic [15:0] drum_tab [2*setc_pkg::NRANGE];
  logic [setc_pkg::STW-1:0] status;
  logic [setc_pkg::STW-1:0] mask;
  logic [setc_pkg::STW-1:0] events;
  logic        req;
  logic        wr;
  logic        rd_status;
  logic [31:0] wmerge;
  logic [31:0] next_rdata;

  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr        = req && wb_we_i;
  assign rd_status = req && !wb_we_i && wb_adr_i == setc_pkg::R_STATUS;

  // Ack one cycle after the request; dropped the cycle after
  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Software-written settings
  always_ff @(posedge mclk) begin
    if (reset) begin
      tmr10_preset <= '0;
      tmrms_preset <= '0;
      knob_range   <= '0;
      fast_preset  <= '0;
      drum_base    <= '0;
      mask         <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        setc_pkg::R_TMR10_PRESET: tmr10_preset <= wmerge[13:0];
        setc_pkg::R_TMRMS_PRESET: tmrms_preset <= wmerge[13:0];
        setc_pkg::R_KNOB_RANGE:   knob_range <= wmerge[3:0];
        setc_pkg::R_FAST_PRESET:  fast_preset <= wmerge[13:0];
        setc_pkg::R_DRUM_BASE:    drum_base <= wmerge[3:0];
        setc_pkg::R_MASK:         mask <= wmerge[setc_pkg::STW-1:0];
        default: ;
      endcase
    end
  end

  // Range table, pairs of low and high limits
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 2*setc_pkg::NRANGE; i++) drum_tab[i] <= '0;
    end else if (wr && wb_adr_i[7:6] == setc_pkg::R_TABLE[7:6]) begin
      drum_tab[wb_adr_i[5:2]] <= wmerge[15:0];
    end
  end

  // Old value for the byte-lane merge
  always_comb begin
    case (wb_adr_i)
      setc_pkg::R_TMR10_PRESET: wmerge = {18'h00000, tmr10_preset};
      setc_pkg::R_TMRMS_PRESET: wmerge = {18'h00000, tmrms_preset};
      setc_pkg::R_KNOB_RANGE:   wmerge = {28'h0000000, knob_range};
      setc_pkg::R_FAST_PRESET:  wmerge = {18'h00000, fast_preset};
      setc_pkg::R_DRUM_BASE:    wmerge = {28'h0000000, drum_base};
      setc_pkg::R_MASK:         wmerge = {25'h0000000, mask};
      default: wmerge = (wb_adr_i[7:6] == setc_pkg::R_TABLE[7:6]) ?
                        {16'h0000, drum_tab[wb_adr_i[5:2]]} : '0;
    endcase
    wmerge = merge(wmerge, wb_dat_i, wb_sel_i);
  end

  // --------------------------------------------------------------
  // Timebase: 1 ms prescaler and decade chain
  // --------------------------------------------------------------
  logic [31:0] ms_cnt;
  logic [3:0]  dec [3];
  logic [3:0]  tb;

  assign tb[setc_pkg::TB_1MS]  = ms_cnt == 32'(MS_CYCLES - 1);
  assign tb[setc_pkg::TB_10M]  = tb[0] && dec[0] == setc_pkg::DECADE_LAST;
  assign tb[setc_pkg::TB_100M] = tb[1] && dec[1] == setc_pkg::DECADE_LAST;
  assign tb[setc_pkg::TB_1S]   = tb[2] && dec[2] == setc_pkg::DECADE_LAST;

  // Free-running, so a timer's first step may come early by up to one
  // step; this trades start accuracy for one shared prescaler
  always_ff @(posedge mclk) begin
    if (reset) begin
      ms_cnt <= '0;
      for (int i = 0; i < 3; i++) dec[i] <= '0;
    end else begin
      ms_cnt <= tb[0] ? '0 : ms_cnt + 32'h1;
      for (int i = 0; i < 3; i++) begin
        if (tb[i]) dec[i] <= tb[i+1] ? '0 : dec[i] + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // Scan-sampled one-shots and latch
  // --------------------------------------------------------------
  setc_pkg::setc_cond_t cq;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cq <= '0;
      unit_out.rise_out <= 1'b0;
      unit_out.fall_out <= 1'b0;
    end else if (scan_tick) begin
      cq <= cond;
      unit_out.rise_out <= cond.rise_in && !cq.rise_in;
      unit_out.fall_out <= !cond.fall_in && cq.fall_in;
    end
  end

  // Reset dominates a simultaneous set
  always_ff @(posedge mclk) begin
    if (reset) begin
      unit_out.latch_q <= 1'b0;
    end else if (scan_tick) begin
      if (cond.latch_reset) begin
        unit_out.latch_q <= 1'b0;
      end else if (cond.latch_set) begin
        unit_out.latch_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Decrementing timers
  // --------------------------------------------------------------
  logic [13:0] t_pre [setc_pkg::NTIM];
  logic [setc_pkg::NTIM-1:0] t_tick;
  logic [13:0] t_present [setc_pkg::NTIM];
  logic [setc_pkg::NTIM-1:0] done_q;

  always_comb begin
    t_pre[setc_pkg::T_10MS] = tmr10_preset;
    t_tick[setc_pkg::T_10MS] = tb[setc_pkg::TB_10M];
    t_pre[setc_pkg::T_MS] = tmrms_preset;
    t_tick[setc_pkg::T_MS] = tb[setc_pkg::TB_1MS];
    t_pre[setc_pkg::T_KNOB] = knob_val(knob_set);
    t_tick[setc_pkg::T_KNOB] = tb[setc_pkg::TB_100M];
    t_pre[setc_pkg::T_KNOB1] = knob_val(knob_one);
    t_tick[setc_pkg::T_KNOB1] = range_tick(knob_range[1:0], tb);
    t_pre[setc_pkg::T_KNOB2] = knob_val(knob_two);
    t_tick[setc_pkg::T_KNOB2] = range_tick(knob_range[3:2], tb);
  end

  for (genvar g = 0; g < setc_pkg::NTIM; g++) begin : g_tmr
    setc_down_timer #(.W(setc_pkg::TW)) u_tmr (
      .mclk    (mclk),
      .reset   (reset),
      .tick    (t_tick[g]),
      .run     (cq.timer_run[g]),
      .preset  (t_pre[g]),
      .present (t_present[g]),
      .done    (unit_out.timer_done[g])
    );
  end

  // Previous done flags, for completion events
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_q <= '0;
    end else begin
      done_q <= unit_out.timer_done;
    end
  end

  // --------------------------------------------------------------
  // Drum range counter
  // --------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      drum_count <= '0;
    end else if (scan_tick) begin
      if (cond.drum_clear) begin
        drum_count <= '0;
      end else if (cond.drum_up && !cq.drum_up) begin
        drum_count <= drum_count + 16'h0001;
      end else if (cond.drum_down && !cq.drum_down) begin
        drum_count <= drum_count - 16'h0001;
      end
    end
  end

  // Only the first drum_base ranges are live
  always_ff @(posedge mclk) begin
    if (reset) begin
      unit_out.drum_result <= '0;
    end else begin
      for (int i = 0; i < setc_pkg::NRANGE; i++) begin
        unit_out.drum_result[i] <= 4'(i) < drum_base &&
          drum_count >= drum_tab[2*i] && drum_count <= drum_tab[2*i+1];
      end
    end
  end

  // --------------------------------------------------------------
  // Fast up counter
  // --------------------------------------------------------------
  logic        pulse_q;
  logic        fast_edge;
  logic        fast_hit;
  logic        fast_pend;
  logic [13:0] fast_limit;

  assign fast_limit = (fast_preset == '0) ?
                      setc_pkg::FAST_ZERO_PRESET : fast_preset;
  assign fast_edge  = field.count_pulse && !pulse_q &&
                      field.gate && !field.clear;
  assign fast_hit   = fast_edge && fast_count + 14'h1 >= fast_limit;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_q    <= 1'b0;
      fast_count <= '0;
    end else begin
      pulse_q <= field.count_pulse;
      if (field.clear || fast_hit) begin
        fast_count <= '0;
      end else if (fast_edge) begin
        fast_count <= fast_count + 14'h1;
      end
    end
  end

  // A hit waits for the scan boundary, then shows for one scan
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_pend <= 1'b0;
      unit_out.fast_count_done_flag <= 1'b0;
    end else begin
      if (scan_tick) begin
        unit_out.fast_count_done_flag <= fast_pend || fast_hit;
      end
      // A hit on the tick itself is shown now, never a second scan
      fast_pend <= (fast_hit || fast_pend) && !scan_tick;
    end
  end

  // --------------------------------------------------------------
  // Word copy
  // --------------------------------------------------------------
  logic [15:0] copy_val;

  assign copy_val = wmerge[setc_pkg::COPY_SEL_BIT] ?
                    {2'h0, fast_count} : wmerge[15:0];

  // Source is the fast count or the written constant
  always_ff @(posedge mclk) begin
    if (reset) begin
      copy_dest <= '0;
      copy_zero <= 1'b0;
    end else if (wr && wb_adr_i == setc_pkg::R_COPY) begin
      copy_dest <= copy_val;
      copy_zero <= copy_val == 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // Interrupt status, clear on read, set wins
  // --------------------------------------------------------------
  always_comb begin
    events = '0;
    events[setc_pkg::ST_FAST] = fast_hit;
    events[setc_pkg::ST_TMR +: setc_pkg::NTIM] =
      unit_out.timer_done & ~done_q;
    events[setc_pkg::ST_ZERO] = wr && wb_adr_i == setc_pkg::R_COPY &&
                                copy_val == 16'h0000;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= (rd_status ? '0 : status) | events;
    end
  end

  assign irq = |(status & mask);

  // Read data, zero for unmapped words
  always_comb begin
    case (wb_adr_i)
      setc_pkg::R_TMR10_PRESET: next_rdata = {18'h00000, tmr10_preset};
      setc_pkg::R_TMRMS_PRESET: next_rdata = {18'h00000, tmrms_preset};
      setc_pkg::R_KNOB_RANGE:   next_rdata = {28'h0000000, knob_range};
      setc_pkg::R_FAST_PRESET:  next_rdata = {18'h00000, fast_preset};
      setc_pkg::R_FAST_COUNT:   next_rdata = {18'h00000, fast_count};
      setc_pkg::R_COPY:  next_rdata = {15'h0000, copy_zero, copy_dest};
      setc_pkg::R_DRUM_BASE:    next_rdata = {28'h0000000, drum_base};
      setc_pkg::R_DRUM_COUNT:   next_rdata = {16'h0000, drum_count};
      setc_pkg::R_DRUM_RESULT:
        next_rdata = {24'h000000, unit_out.drum_result};
      setc_pkg::R_STATUS:       next_rdata = {25'h0000000, status};
      setc_pkg::R_MASK:         next_rdata = {25'h0000000, mask};
      setc_pkg::R_UNIT_STATE:
        next_rdata = {21'h000000, unit_out.fast_count_done_flag,
                      unit_out.timer_done, 2'h0, unit_out.latch_q,
                      unit_out.fall_out, unit_out.rise_out};
      default: next_rdata = (wb_adr_i[7:6] == setc_pkg::R_TABLE[7:6]) ?
                            {16'h0000, drum_tab[wb_adr_i[5:2]]} : '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_rise_one_scan: assert property (
    scan_tick && cond.rise_in && !cq.rise_in
      |=> unit_out.rise_out until_with scan_tick)
    else $error("rising pulse not one scan");
  a_fall_one_scan: assert property (
    scan_tick && !cond.fall_in && cq.fall_in |=> unit_out.fall_out)
    else $error("falling pulse missing");
  a_latch_set_hold: assert property (
    scan_tick && cond.latch_set && !cond.latch_reset
      |=> unit_out.latch_q)
    else $error("latch did not set");
  a_latch_reset_wins: assert property (
    scan_tick && cond.latch_reset |=> !unit_out.latch_q)
    else $error("latch reset did not win");
  a_fast_wraps: assert property (
    fast_hit |=> fast_count == '0 && status[setc_pkg::ST_FAST])
    else $error("fast count not cleared at preset");
  a_fast_done_scan: assert property (
    $rose(unit_out.fast_count_done_flag) |-> $past(scan_tick))
    else $error("fast done flag not on scan edge");
  a_fast_zero_preset: assert property (
    fast_preset == '0 && fast_edge && fast_count == 14'h270F
      |=> fast_count == '0)
    else $error("zero preset not ten thousand");
  a_copy_zero_flag: assert property (
    wr && wb_adr_i == setc_pkg::R_COPY
      |=> copy_zero == (copy_dest == 16'h0000) && status[setc_pkg::ST_ZERO]
          == $past(copy_val == 16'h0000 || status[setc_pkg::ST_ZERO]))
    else $error("copy zero flag wrong");
  a_wb_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  c_fast_done: cover property (fast_hit ##[1:300] scan_tick);
  c_latch_both: cover property (
    scan_tick && cond.latch_set && cond.latch_reset);
  c_irq_rise: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** sim/setc_field_model.sv ***
// Far-side model: program scan strobe and field count pulses.
// Assumes one clock; the bench asks for each count pulse.
`timescale 1ns/1ps
`default_nettype none
module setc_field_model #(
  parameter int SCAN = 8
) (
  input  wire logic             mclk,      // Block clock
  input  wire logic             reset,     // Sync, active high
  input  wire logic             pulse_req, // Ask for one pulse
  input  wire logic             gate,      // Gate level
  input  wire logic             cnt_clear, // Counter reset level
  output logic                  scan_tick, // Scan strobe
  output setc_pkg::setc_field_t field      // Field inputs
);
  // ------------------------------------------------------------
  // Scan strobe and pulse shaper
  // ------------------------------------------------------------
  int         cnt;
  logic [1:0] hold;
  // Pulse lasts two cycles so the edge detector sees a clean rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt <= 0;
      scan_tick <= 1'b0;
      hold <= 2'h0;
    end else begin
      cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
      scan_tick <= (cnt == SCAN - 1);
      hold <= pulse_req ? 2'h3 : hold >> 1;
    end
  end
  // Counter reset level comes from the bench so its gating is tested
  assign field = '{count_pulse: hold[0], gate: gate, clear: cnt_clear};
endmodule
`default_nettype wire

// *** sim/setc_unit_tb.sv ***
// Bench for the scan timer/counter unit: bus tasks, directed tests.
// Assumes the field model makes the scan strobe and count pulses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
`define WAITHI(s) for (n = 0; n < 999 && (s) !== 1'b1; n++) @(posedge mclk);
module setc_unit_tb;
  logic mclk = 1'b0, reset = 1'b1, pulse_req = 1'b0, gate = 1'b0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, clr = 1'b0, ack, irq, scan_tick;
  logic [7:0] adr = 8'h00, knob = 8'h03;
  logic [31:0] wdat = 32'h0, rdat, q;
  setc_pkg::setc_cond_t cond = '0;
  setc_pkg::setc_field_t field;
  setc_pkg::setc_out_t uo;
  int mismatches = 0, total_checks = 0, n;
  always #2 mclk = ~mclk;
  setc_field_model #(.SCAN(8)) FM (.mclk(mclk), .reset(reset),
    .pulse_req(pulse_req), .gate(gate), .scan_tick(scan_tick),
    .field(field), .cnt_clear(clr));
  // Short millisecond prescaler keeps the timer test brief
  setc_unit #(.MS_CYCLES(10)) DUT (.mclk(mclk), .reset(reset),
    .scan_tick(scan_tick), .cond(cond), .field(field), .knob_set(knob),
    .knob_one(knob), .knob_two(knob), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .unit_out(uo), .irq(irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Classic cycle: request held until ack is sampled high
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    `WAITHI(ack)
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 999) begin mismatches++; give_verdict(); end
    @(posedge mclk);
  endtask
  // Waits for a scan strobe, then lets the unit outputs land
  task automatic scans();
    `WAITHI(scan_tick)
    if (n >= 999) begin mismatches++; give_verdict(); end
    repeat (2) @(posedge mclk);
  endtask
  task automatic pulse();
    pulse_req <= 1'b1;
    @(posedge mclk);
    pulse_req <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    cond.rise_in <= 1'b1;
    cond.fall_in <= 1'b1;
    scans();
    `CHK("rise", 1'b1, uo.rise_out)
    scans();
    `CHK("rise end", 1'b0, uo.rise_out)
    cond.rise_in <= 1'b0;
    cond.fall_in <= 1'b0;
    scans();
    `CHK("fall", 1'b1, uo.fall_out)
    scans();
    `CHK("fall end", 1'b0, uo.fall_out)
    cond.latch_set <= 1'b1;
    scans();
    cond.latch_set <= 1'b0;
    scans();
    `CHK("latch hold", 1'b1, uo.latch_q)
    cond.latch_set <= 1'b1;
    cond.latch_reset <= 1'b1;
    scans();
    `CHK("latch both", 1'b0, uo.latch_q)
    $display("scan bit test done");
    bus(setc_pkg::R_MASK, 1'b1, 32'h1);
    bus(setc_pkg::R_FAST_PRESET, 1'b1, 32'h3);
    gate <= 1'b1;
    pulse();
    clr <= 1'b1;
    pulse();
    clr <= 1'b0;
    bus(setc_pkg::R_FAST_COUNT, 1'b0, 32'h0);
    `CHK("clear", 32'h0, q)
    pulse();
    pulse();
    bus(setc_pkg::R_FAST_COUNT, 1'b0, 32'h0);
    `CHK("count", 32'h2, q)
    gate <= 1'b0;
    pulse();
    gate <= 1'b1;
    pulse();
    `WAITHI(uo.fast_count_done_flag)
    `CHK("flag", 1'b1, uo.fast_count_done_flag)
    scans();
    `CHK("flag end", 1'b0, uo.fast_count_done_flag)
    `CHK("irq", 1'b1, irq)
    bus(setc_pkg::R_FAST_COUNT, 1'b0, 32'h0);
    `CHK("wrap", 32'h0, q)
    bus(setc_pkg::R_STATUS, 1'b0, 32'h0);
    `CHK("status", 32'h1, q & 32'h1)
    `CHK("irq clear", 1'b0, irq)
    $display("fast counter test done");
    bus(setc_pkg::R_COPY, 1'b1, 32'h0);
    bus(setc_pkg::R_COPY, 1'b0, 32'h0);
    `CHK("copy zero", 32'h10000, q)
    bus(setc_pkg::R_COPY, 1'b1, 32'h5);
    bus(setc_pkg::R_COPY, 1'b0, 32'h0);
    `CHK("copy", 32'h5, q)
    pulse();
    bus(setc_pkg::R_COPY, 1'b1, 32'h10000);
    bus(setc_pkg::R_COPY, 1'b0, 32'h0);
    `CHK("copy count", 32'h1, q)
    bus(8'h3C, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
    $display("copy test done");
    bus(setc_pkg::R_DRUM_BASE, 1'b1, 32'h1);
    bus(setc_pkg::R_TABLE + 8'h04, 1'b1, 32'h2);
    bus(setc_pkg::R_DRUM_RESULT, 1'b0, 32'h0);
    `CHK("in range", 32'h1, q)
    bus(setc_pkg::R_TABLE, 1'b1, 32'h5);
    bus(setc_pkg::R_DRUM_RESULT, 1'b0, 32'h0);
    `CHK("out of range", 32'h0, q)
    $display("drum test done");
    bus(setc_pkg::R_TMRMS_PRESET, 1'b1, 32'h3);
    cond.timer_run[1] <= 1'b1;
    scans();
    `CHK("timing", 1'b0, uo.timer_done[1])
    `WAITHI(uo.timer_done[1])
    `CHK("timed out", 1'b1, uo.timer_done[1])
    `CHK("ms steps", 1'b1, n > 15 && n < 40)
    bus(setc_pkg::R_KNOB_RANGE, 1'b1, 32'h2);
    cond.timer_run[3] <= 1'b1;
    scans();
    `CHK("knob timing", 1'b0, uo.timer_done[3])
    `WAITHI(uo.timer_done[3])
    `CHK("knob done", 1'b1, uo.timer_done[3])
    `CHK("knob steps", 1'b1, n > 150 && n < 400)
    cond.timer_run[1] <= 1'b0;
    cond.timer_run[3] <= 1'b0;
    scans();
    `CHK("reload", 1'b0, uo.timer_done[1])
    `CHK("knob reload", 1'b0, uo.timer_done[3])
    $display("timer test done");
    give_verdict();
  end
endmodule
`default_nettype wire
